// ==== dv/pif_regs_asserts.sv ====
// checker for the flag register block, bound to pif_regs
// assumes one clock domain and the default parameters
`timescale 1ns/1ps
module pif_regs_asserts (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  // events and flag views
  input wire logic        osc_failsafe_event,
  input wire logic        conversion_done_event,
  input wire logic        comparator_one_event,
  input wire logic        comparator_two_event,
  input wire logic [7:0]  periph_flags_clock_adc,
  input wire logic [7:0]  periph_flags_analog_events
);
  // ****
  // properties
  // ****
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // only a committed one-write may drop the zero-cross flag
  wire logic clr_an = psel && penable && pready && pwrite && pstrb[0] && paddr == pif_pkg::OFS_FLAGS_ANALOG;
  property p_zc; periph_flags_analog_events[6] && !(clr_an && pwdata[6]) |=> periph_flags_analog_events[6]; endproperty
  a_zc: assert property (p_zc) else $error("zero-cross flag lost");
  property p_cmp2; comparator_two_event |=> periph_flags_analog_events[1]; endproperty
  a_cmp2: assert property (p_cmp2) else $error("cmp two flag");
  property p_cmp1; comparator_one_event |=> periph_flags_analog_events[0]; endproperty
  a_cmp1: assert property (p_cmp1) else $error("cmp one flag");
  property p_conv; conversion_done_event |=> periph_flags_clock_adc[0]; endproperty
  a_conv: assert property (p_conv) else $error("conversion flag");
  property p_rst; $rose(presetn) |-> (periph_flags_clock_adc | periph_flags_analog_events) == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("flags after reset");
  property p_unimpl; ((periph_flags_clock_adc & ~pif_pkg::IMPL_CLOCK_ADC) | (periph_flags_analog_events
    & ~pif_pkg::IMPL_ANALOG)) == 8'h00; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
  property p_osc; osc_failsafe_event |=> periph_flags_clock_adc[7]; endproperty
  a_osc: assert property (p_osc) else $error("failsafe flag");
endmodule
bind pif_regs pif_regs_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .osc_failsafe_event(osc_failsafe_event), .conversion_done_event(conversion_done_event),
  .comparator_one_event(comparator_one_event), .comparator_two_event(comparator_two_event),
  .periph_flags_clock_adc(periph_flags_clock_adc), .periph_flags_analog_events(periph_flags_analog_events));

// ==== dv/pif_regs_bench.sv ====
// self-checking bench for the flag register block
// assumes pif_regs with default parameters on a 10 MHz pclk
`timescale 1ns/1ps
module pif_regs_bench;
  // ****
  // stimulus and checking
  // ****
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, zp;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, xs = 32'd90883;
  logic [5:0]  ev = 6'h00;
  logic [7:0]  fca, fan, ea, eb;
  logic [32:0] q[$];
  int          err_total = 0, check_count = 0;
  pif_regs dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_failsafe_event(ev[0]), .clock_switch_ready_event(ev[1]), .conversion_done_event(ev[2]),
    .comparator_one_event(ev[3]), .comparator_two_event(ev[4]), .zero_cross_detector(ev[5]),
    .periph_flags_clock_adc(fca), .periph_flags_analog_events(fan), .irq(irq));
  always #50 pclk = ~pclk;
  function automatic logic [31:0] rnd(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task chk(input logic [32:0] s, input logic [32:0] e, input string nm);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // the request is held until pready is seen at an edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, paddr, pwrite, pwdata} <= {1'b1, a, w, d};
    q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    {psel, penable} <= 2'b00;
    // a slave that never answers ends the run as a failure
    if (n >= 20)
    begin
      err_total++;
      results;
    end
  endtask
  task pulse(input logic [5:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= {v[5], 5'h00};
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
      chk({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front(), "apb answer");
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    zp = 1'b0;
    apb(pif_pkg::OFS_FLAGS_CLOCK_ADC, 0, 0, 33'h0);
    apb(pif_pkg::OFS_FLAGS_ANALOG, 0, 0, 33'h0);
    apb(12'h020, 0, 0, {1'b1, 32'h0});
    // masks stay 0 here, so every set shows flags ignore enables
    repeat (8)
    begin
      xs = rnd(xs);
      pulse(xs[5:0]);
      ea = {xs[0], xs[1], 5'h00, xs[2]};
      eb = {1'b0, xs[5] ^ zp, 4'h0, xs[4], xs[3]};
      zp = xs[5];
      apb(pif_pkg::OFS_FLAGS_CLOCK_ADC, 0, 0, {25'h0, ea});
      apb(pif_pkg::OFS_FLAGS_ANALOG, 0, 0, {25'h0, eb});
      apb(pif_pkg::OFS_FLAGS_CLOCK_ADC, 1, 32'hFF, 33'h0);
      apb(pif_pkg::OFS_FLAGS_ANALOG, 1, 32'hFF, 33'h0);
    end
    pulse({zp, 5'h08});
    apb(pif_pkg::OFS_MASK_ANALOG, 1, 32'hFF, 33'h0);
    apb(pif_pkg::OFS_MASK_ANALOG, 0, 0, {25'h0, pif_pkg::IMPL_ANALOG});
    chk({32'h0, irq}, 33'h1, "irq raised");
    apb(pif_pkg::OFS_MASK_ANALOG, 1, 32'h0, 33'h0);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq}, 33'h0, "irq masked");
    apb(pif_pkg::OFS_MASK_ANALOG, 1, 32'hFF, 33'h0);
    apb(pif_pkg::OFS_FLAGS_ANALOG, 1, 32'h01, 33'h0);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq}, 33'h0, "irq cleared");
    pulse(6'h01);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(pif_pkg::OFS_FLAGS_CLOCK_ADC, 0, 0, 33'h0);
    apb(pif_pkg::OFS_FLAGS_ANALOG, 0, 0, 33'h0);
    results;
  end
  // the run needs some 200 cycles; 3000 leaves ample margin
  initial
  begin
    #(3000 * 100);
    err_total++;
    results;
  end
endmodule

// ==== logic/pif_pkg.sv ====
// constants for the peripheral interrupt flag register block
// assumes a 32-bit apb slave with word-aligned registers
package pif_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int unsigned ADDR_W              = 12;
  localparam logic [11:0] OFS_FLAGS_CLOCK_ADC = 12'h000;
  localparam logic [11:0] OFS_FLAGS_ANALOG    = 12'h004;
  localparam logic [11:0] OFS_MASK_CLOCK_ADC  = 12'h008;
  localparam logic [11:0] OFS_MASK_ANALOG     = 12'h00C;
  localparam logic [11:0] OFS_ZC_EDGE_CTRL    = 12'h010;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned BIT_OSC_FAILSAFE    = 7;
  localparam int unsigned BIT_CLOCK_SWITCH    = 6;
  localparam int unsigned BIT_CONVERSION_DONE = 0;
  localparam int unsigned BIT_ZERO_CROSS      = 6;
  localparam int unsigned BIT_CMP_TWO         = 1;
  localparam int unsigned BIT_CMP_ONE         = 0;
  localparam int unsigned BIT_ZC_RISE_EN      = 0;
  localparam int unsigned BIT_ZC_FALL_EN      = 1;

  // ****************************************
  // implemented bits and reset values
  // ****************************************
  localparam logic [7:0] IMPL_CLOCK_ADC = 8'hC1;
  localparam logic [7:0] IMPL_ANALOG    = 8'h43;
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic [7:0] RST_MASK       = 8'h00;
  localparam logic [1:0] RST_ZC_EDGE    = 2'h3;
  localparam logic [1:0] ZC_EDGE_IMPL   = 2'h3;

endpackage

// ==== logic/pif_regs.sv ====
// peripheral interrupt flag registers with apb slave, mask and interrupt
// assumes event inputs come from logic on pclk, so they are not synchronised
//
// Notes on behaviour
// - zero-cross flag bit 6 of second register sets on enabled edge, sticks
// - comparator two flag bit 1 of second register sets and sticks
// - comparator one flag bit 0 of second register sets and sticks
// - flags set regardless of the masks; only the zero-cross flag also needs its edge enable
// - all implemented flags reset to zero on every reset; read, write, set
// - unimplemented flag positions always read as zero
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module pif_regs
#(
  parameter logic HAS_CMP_TWO = 1'b1
)
(
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,

  // apb slave
  input  wire logic [pif_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,

  // event sources
  input  wire logic                         osc_failsafe_event,
  input  wire logic                         clock_switch_ready_event,
  input  wire logic                         conversion_done_event,
  input  wire logic                         zero_cross_detector,
  input  wire logic                         comparator_one_event,
  input  wire logic                         comparator_two_event,

  // flag views and interrupt
  output logic      [7:0]                   periph_flags_clock_adc,
  output logic      [7:0]                   periph_flags_analog_events,
  output logic                              irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]  flags_clk;
    logic [7:0]  flags_ana;
    logic [7:0]  mask_clk;
    logic [7:0]  mask_ana;
    logic [1:0]  zc_edge;
    logic        zc_prev;
    logic        ready;
    logic        err;
    logic [31:0] rdata;
    logic        irq;
  } pif_state_s;

  localparam pif_state_s RST_STATE = '{
    flags_clk : pif_pkg::RST_FLAGS,
    flags_ana : pif_pkg::RST_FLAGS,
    mask_clk  : pif_pkg::RST_MASK,
    mask_ana  : pif_pkg::RST_MASK,
    zc_edge   : pif_pkg::RST_ZC_EDGE,
    zc_prev   : 1'b0,
    ready     : 1'b0,
    err       : 1'b0,
    rdata     : 32'h0000_0000,
    irq       : 1'b0
  };

  // comparator two only exists on the larger part
  localparam logic [7:0] IMPL_ANA =
    pif_pkg::IMPL_ANALOG & ~({7'h00, ~HAS_CMP_TWO} << pif_pkg::BIT_CMP_TWO);

  pif_state_s st_q;
  pif_state_s st_d;

  // ****************************************
  // helpers
  // ****************************************
  // set wins over a clear in the same cycle, so no event is lost
  function automatic logic [7:0] pif_flag_next(
    input logic [7:0] cur,
    input logic [7:0] set,
    input logic [7:0] clr,
    input logic [7:0] impl
  );
    pif_flag_next = ((cur & ~clr) | set) & impl;
  endfunction

  function automatic logic [31:0] pif_byte(input logic [7:0] val);
    pif_byte = {24'h00_0000, val};
  endfunction

  // one address compare, shared by every register decode
  function automatic logic pif_hit(
    input logic [pif_pkg::ADDR_W-1:0] addr,
    input logic [11:0]                ofs
  );
    pif_hit = (addr == ofs);
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  logic       acc;
  logic       done;
  logic       wr;
  logic       hit_fclk;
  logic       hit_fana;
  logic       hit_mclk;
  logic       hit_mana;
  logic       hit_zc;
  logic       mapped;
  logic [7:0] wbyte;

  assign acc      = psel & penable;
  assign done     = acc & st_q.ready;
  assign wr       = done & pwrite & pstrb[0];
  assign wbyte    = pwdata[7:0];
  assign hit_fclk = pif_hit(paddr, pif_pkg::OFS_FLAGS_CLOCK_ADC);
  assign hit_fana = pif_hit(paddr, pif_pkg::OFS_FLAGS_ANALOG);
  assign hit_mclk = pif_hit(paddr, pif_pkg::OFS_MASK_CLOCK_ADC);
  assign hit_mana = pif_hit(paddr, pif_pkg::OFS_MASK_ANALOG);
  assign hit_zc   = pif_hit(paddr, pif_pkg::OFS_ZC_EDGE_CTRL);
  assign mapped   = hit_fclk | hit_fana | hit_mclk | hit_mana | hit_zc;

  // ****************************************
  // event collection
  // ****************************************
  logic       zc_rise;
  logic       zc_fall;
  logic [7:0] set_clk;
  logic [7:0] set_ana;
  logic [7:0] clr_clk;
  logic [7:0] clr_ana;

  // edges qualified by the detector's edge enables only
  assign zc_rise = zero_cross_detector & ~st_q.zc_prev
                   & st_q.zc_edge[pif_pkg::BIT_ZC_RISE_EN];
  assign zc_fall = ~zero_cross_detector & st_q.zc_prev
                   & st_q.zc_edge[pif_pkg::BIT_ZC_FALL_EN];

  // no mask or global enable term here on purpose
  always_comb
  begin
    set_clk = 8'h00;
    set_ana = 8'h00;
    set_clk[pif_pkg::BIT_OSC_FAILSAFE]    = osc_failsafe_event;
    set_clk[pif_pkg::BIT_CLOCK_SWITCH]    = clock_switch_ready_event;
    set_clk[pif_pkg::BIT_CONVERSION_DONE] = conversion_done_event;
    set_ana[pif_pkg::BIT_ZERO_CROSS]      = zc_rise | zc_fall;
    set_ana[pif_pkg::BIT_CMP_TWO]         = comparator_two_event;
    set_ana[pif_pkg::BIT_CMP_ONE]         = comparator_one_event;
  end

  // software clears a flag by writing a one to it
  assign clr_clk = (wr & hit_fclk) ? wbyte : 8'h00;
  assign clr_ana = (wr & hit_fana) ? wbyte : 8'h00;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_d = st_q;

    st_d.zc_prev = zero_cross_detector;

    // sticky flags, implemented bits only
    st_d.flags_clk = pif_flag_next(st_q.flags_clk, set_clk, clr_clk,
                                   pif_pkg::IMPL_CLOCK_ADC);
    st_d.flags_ana = pif_flag_next(st_q.flags_ana, set_ana, clr_ana,
                                   IMPL_ANA);

    // configuration writes
    if (wr & hit_mclk)
    begin
      st_d.mask_clk = wbyte & pif_pkg::IMPL_CLOCK_ADC;
    end
    if (wr & hit_mana)
    begin
      st_d.mask_ana = wbyte & IMPL_ANA;
    end
    if (wr & hit_zc)
    begin
      st_d.zc_edge = wbyte[1:0] & pif_pkg::ZC_EDGE_IMPL;
    end

    // one wait state: ready rises in the second access cycle
    st_d.ready = acc & ~st_q.ready;
    st_d.err   = 1'b0;
    st_d.rdata = 32'h0000_0000;
    if (acc & ~st_q.ready)
    begin
      st_d.err = ~mapped;
      if (~pwrite)
      begin
        // unmapped reads return zero alongside the error response
        unique case (1'b1)
          hit_fclk:
          begin
            st_d.rdata = pif_byte(st_q.flags_clk);
          end
          hit_fana:
          begin
            st_d.rdata = pif_byte(st_q.flags_ana);
          end
          hit_mclk:
          begin
            st_d.rdata = pif_byte(st_q.mask_clk);
          end
          hit_mana:
          begin
            st_d.rdata = pif_byte(st_q.mask_ana);
          end
          hit_zc:
          begin
            st_d.rdata = {30'h0000_0000, st_q.zc_edge};
          end
          default:
          begin
            st_d.rdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // level interrupt from the flags as they will stand
    st_d.irq = |({st_d.flags_clk, st_d.flags_ana}
                 & {st_d.mask_clk, st_d.mask_ana});
  end

  // ****************************************
  // registers
  // ****************************************
  // every reset source lands here, so flags clear on all of them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= RST_STATE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata                     = st_q.rdata;
  assign pready                     = st_q.ready;
  assign pslverr                    = st_q.err;
  assign irq                        = st_q.irq;
  assign periph_flags_clock_adc     = st_q.flags_clk;
  assign periph_flags_analog_events = st_q.flags_ana;

endmodule
